// file: hdl/mmdp_phy_ctrl.sv
// ============================================================
// mmdp_phy_ctrl: phy-side partner of a mac on the media independent interface
// assumes mac drives mdc, mdio and the transmit pins; software uses the plain port
//
// Notes on behaviour
// - management clock up to 25 mhz, no minimum
// - up to 32 stations share mdio
// - one register access per 64-bit frame, untimed
// - frame order fixed, start pattern 01
// - first read turnaround bit undriven
// - phy drives zero then register data
// - receive nibble, error, valid and clock
// - transmit nibble and enable on phy clock
// - 10 mb/s transmit collision after seven bits
// - collision during receive reported immediately
// - heartbeat pulse after each half-duplex 10 mb/s packet
// - carrier sense raised on valid receive data
// - carrier sense per duplex, drops after packet
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
module mmdp_phy_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // software port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rd_data,
  // management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // receive pins
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  // transmit pins
  output logic tx_clk,
  input wire logic [3:0] txd,
  input wire logic tx_en,
  // carrier and collision
  output logic crs,
  output logic col
);
  import mmdp_pkg::*;

  mmdp_ctrl_t ctrl;
  mmdp_rx_t rx_word;
  logic rx_pending;
  logic [4:0] mg_sel;
  logic [15:0] mregs [MG_REGS];
  logic mdc_rise;
  logic mdio_s;
  logic [4:0] tx_s;
  mmdp_mg_state_t mg_state;
  logic [4:0] bit_cnt;
  logic [5:0] ones_cnt;
  logic op_read;
  logic op_first;
  logic [15:0] shreg;
  logic [15:0] drv_data;
  logic phy_hit;
  logic [4:0] reg_idx;
  logic mg_wr;
  logic [15:0] mg_wr_data;
  logic frame_err;
  logic [5:0] div_cnt;
  logic mii_clk;
  logic mii_fall;
  logic tx_act;
  logic [3:0] tx_last;
  logic [15:0] tx_count;
  logic tx_new;
  logic rx_active;
  logic rx_led;
  logic [9:0] coll_cnt;
  logic [9:0] sqe_cnt;
  logic tx_coll;
  logic next_col;
  logic [5:0] half;

  // ============================================================
  // input synchronisers
  mmdp_edge u_mdc_edge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin(mdc),
    .rise(mdc_rise),
    .fall()
  );

  mmdp_sync2 #(.WIDTH(1)) u_mdio_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(mdio_in),
    .dout(mdio_s)
  );

  mmdp_sync2 #(.WIDTH(5)) u_tx_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din({tx_en, txd}),
    .dout(tx_s)
  );

  // ============================================================
  // software registers
  // control and selection registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '{phy_addr: PHY_ADDR_RST, default: 1'b0};
      mg_sel <= '0;
    end else if (wr_stb) begin
      if (addr == A_CTRL) ctrl <= mmdp_ctrl_t'(wr_data[8:0]);
      if (addr == A_MG_SEL) mg_sel <= wr_data[4:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_stb) begin
      case (addr)
        A_CTRL: rd_data <= {23'h0, ctrl};
        A_STATUS: rd_data <= {23'h0, frame_err, 3'(mg_state), tx_new, col, crs, tx_act,
                              rx_pending};
        A_RX_DATA: rd_data <= {31'h0, rx_pending};
        A_TX_DATA: rd_data <= {tx_count, 12'h0, tx_last};
        A_MG_SEL: rd_data <= {27'h0, mg_sel};
        A_MG_DATA: rd_data <= {16'h0, mregs[mg_sel]};
        default: rd_data <= '0;
      endcase
    end else begin
      rd_data <= '0;
    end
  end

  // phy register file; a management write wins over software
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MG_REGS; i++) begin
        mregs[i] <= '0;
      end
    end else if (mg_wr) begin
      mregs[reg_idx] <= mg_wr_data;
    end else if (wr_stb && addr == A_MG_DATA) begin
      mregs[mg_sel] <= wr_data[15:0];
    end
  end

  // ============================================================
  // management frame responder, stepped by mdc rising edges only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mg_state <= MG_PRE;
      bit_cnt <= '0;
      ones_cnt <= '0;
      op_read <= 1'b0;
      op_first <= 1'b0;
      shreg <= '0;
      drv_data <= '0;
      phy_hit <= 1'b0;
      reg_idx <= '0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      mg_wr <= 1'b0;
      mg_wr_data <= '0;
    end else begin
      mg_wr <= 1'b0;
      if (mdc_rise) begin
        case (mg_state)
          MG_PRE: begin
            if (mdio_s) begin
              if (ones_cnt < PREAMBLE_ONES) ones_cnt <= ones_cnt + 6'h01;
            end else if (ones_cnt == PREAMBLE_ONES) begin
              mg_state <= MG_START;
            end else begin
              ones_cnt <= '0;
            end
          end
          MG_START: begin
            ones_cnt <= '0;
            bit_cnt <= '0;
            mg_state <= mdio_s ? MG_OP : MG_PRE;
          end
          MG_OP: begin
            op_first <= mdio_s;
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt != 5'h00) begin
              bit_cnt <= '0;
              if ({op_first, mdio_s} == OP_READ || {op_first, mdio_s} == OP_WRITE) begin
                op_read <= op_first;
                mg_state <= MG_ADDR;
              end else begin
                mg_state <= MG_PRE;
              end
            end
          end
          MG_ADDR: begin
            shreg <= {shreg[14:0], mdio_s};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == LAST_ADDR_BIT) begin
              bit_cnt <= '0;
              phy_hit <= (shreg[8:4] == ctrl.phy_addr);
              reg_idx <= {shreg[3:0], mdio_s};
              drv_data <= mregs[{shreg[3:0], mdio_s}];
              mg_state <= MG_TA;
            end
          end
          MG_TA: begin
            bit_cnt <= bit_cnt + 5'h01;
            if (op_read) begin
              // line stayed free for the first bit; drive zero, then data
              if (phy_hit && bit_cnt == 5'h00) begin
                mdio_oe <= 1'b1;
                mdio_out <= 1'b0;
              end
              if (bit_cnt != 5'h00) begin
                if (phy_hit) mdio_out <= drv_data[15];
                drv_data <= {drv_data[14:0], 1'b0};
                bit_cnt <= '0;
                mg_state <= MG_DATA;
              end
            end else if (mdio_s == (bit_cnt == 5'h00)) begin
              if (bit_cnt != 5'h00) begin
                bit_cnt <= '0;
                mg_state <= MG_DATA;
              end
            end else begin
              mg_state <= MG_PRE;
            end
          end
          MG_DATA: begin
            bit_cnt <= bit_cnt + 5'h01;
            shreg <= {shreg[14:0], mdio_s};
            if (op_read && phy_hit) begin
              mdio_out <= drv_data[15];
              drv_data <= {drv_data[14:0], 1'b0};
            end
            if (bit_cnt == LAST_DATA_BIT) begin
              mdio_oe <= 1'b0;
              mdio_out <= 1'b0;
              mg_wr <= ~op_read & phy_hit;
              mg_wr_data <= {shreg[14:0], mdio_s};
              bit_cnt <= '0;
              mg_state <= MG_PRE;
            end
          end
          default: begin
            mdio_oe <= 1'b0;
            mg_state <= MG_PRE;
          end
        endcase
      end
    end
  end

  // sticky frame error: the hardware set wins over the clear by status read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_err <= 1'b0;
    end else if (mdc_rise && ((mg_state == MG_START && !mdio_s) ||
                 (mg_state == MG_OP && bit_cnt != 5'h00 && (op_first == mdio_s)) ||
                 (mg_state == MG_TA && !op_read && (mdio_s != (bit_cnt == 5'h00))))) begin
      frame_err <= 1'b1;
    end else if (rd_stb && addr == A_STATUS) begin
      frame_err <= 1'b0;
    end
  end

  // ============================================================
  // link clock divider; this end makes rx_clk and tx_clk
  assign half = ctrl.speed_100 ? HALF_100 : HALF_10;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      mii_clk <= 1'b0;
      mii_fall <= 1'b0;
      rx_clk <= 1'b0;
      tx_clk <= 1'b0;
    end else begin
      mii_fall <= 1'b0;
      if (div_cnt >= half - 6'h01) begin
        div_cnt <= '0;
        mii_clk <= ~mii_clk;
        rx_clk <= ~mii_clk;
        tx_clk <= ~mii_clk;
        mii_fall <= mii_clk;
      end else begin
        div_cnt <= div_cnt + 6'h01;
      end
    end
  end

  // ============================================================
  // receive stream: one nibble per falling link edge, mac samples on rising
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_word <= '0;
      rx_pending <= 1'b0;
      rxd <= '0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
    end else begin
      if (mii_fall) begin
        rx_dv <= rx_pending;
        rx_er <= rx_pending & rx_word.err;
        rxd <= rx_pending ? rx_word.nibble : 4'h0;
      end
      if (wr_stb && addr == A_RX_DATA) begin
        rx_word <= mmdp_rx_t'(wr_data[4:0]);
        rx_pending <= 1'b1;
      end else if (mii_fall) begin
        rx_pending <= 1'b0;
      end
    end
  end

  // ============================================================
  // transmit capture at mid link period; new flag set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_act <= 1'b0;
      tx_last <= '0;
      tx_count <= '0;
      tx_new <= 1'b0;
    end else begin
      if (mii_fall) tx_act <= tx_s[4];
      if (mii_fall && tx_s[4]) begin
        tx_last <= tx_s[3:0];
        tx_count <= tx_count + 16'h0001;
        tx_new <= 1'b1;
      end else if (rd_stb && addr == A_STATUS) begin
        tx_new <= 1'b0;
      end
    end
  end

  // ============================================================
  // carrier sense and collision
  assign rx_active = rx_dv | ctrl.rx_carrier;
  assign tx_coll = ~ctrl.full_duplex & rx_active & tx_act;

  always_comb begin
    next_col = 1'b0;
    if (tx_coll && (rx_led || ctrl.speed_100)) next_col = 1'b1;
    if (tx_coll && coll_cnt >= COL_DELAY_CYC) next_col = 1'b1;
    if (sqe_cnt != 10'h000 && sqe_cnt <= SQE_LEN_CYC) next_col = 1'b1;
  end

  // receive-first tracking, collision bit counter and heartbeat timer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_led <= 1'b0;
      coll_cnt <= '0;
      sqe_cnt <= '0;
    end else begin
      rx_led <= rx_active & (rx_led | ~tx_act);
      coll_cnt <= tx_coll ? ((coll_cnt < COL_DELAY_CYC) ? coll_cnt + 10'h001 : coll_cnt)
                          : 10'h000;
      if (mii_fall && tx_act && !tx_s[4] && !ctrl.full_duplex && !ctrl.speed_100 &&
          ctrl.heartbeat_en) begin
        sqe_cnt <= SQE_DELAY_CYC + SQE_LEN_CYC;
      end else if (sqe_cnt != 10'h000) begin
        sqe_cnt <= sqe_cnt - 10'h001;
      end
    end
  end

  // registered carrier and collision pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crs <= 1'b0;
      col <= 1'b0;
    end else begin
      crs <= rx_active | (~ctrl.full_duplex & tx_act);
      col <= next_col;
    end
  end

  // ============================================================
  // checks
  chk_ta_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mg_state == MG_TA && bit_cnt == 5'h00) |-> !mdio_oe)
    else $error("mdio driven during first turnaround bit");

  chk_ta_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mdc_rise && mg_state == MG_TA && op_read && phy_hit && bit_cnt == 5'h00)
    |=> (mdio_oe && !mdio_out))
    else $error("second turnaround bit not driven low");

  chk_drive_owner: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mdio_oe |-> (op_read && phy_hit && (mg_state == MG_TA || mg_state == MG_DATA)))
    else $error("mdio driven outside an addressed read");

  chk_preamble_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mg_state == MG_PRE ##1 mg_state == MG_START) |-> $past(ones_cnt) == PREAMBLE_ONES)
    else $error("start accepted without full preamble");

  chk_bad_op_resync: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mdc_rise && mg_state == MG_OP && bit_cnt != 5'h00 && op_first == mdio_s)
    |=> (mg_state == MG_PRE && frame_err))
    else $error("invalid opcode not resynchronised");

  chk_rx_present: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mii_fall && rx_pending) |=> (rx_dv && rxd == $past(rx_word.nibble)))
    else $error("pending nibble not presented");

  chk_col_immediate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (tx_coll && rx_led) |=> col)
    else $error("receive collision not immediate");

  chk_col_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($rose(tx_coll) && !rx_led && !ctrl.speed_100 && sqe_cnt == 10'h000) ##0 tx_coll [*8]
    |-> !col)
    else $error("transmit collision reported too early");

  chk_crs_full: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl.full_duplex && !rx_active) |=> !crs)
    else $error("carrier sense without receive in full duplex");

  chk_sqe_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sqe_cnt == SQE_DELAY_CYC + SQE_LEN_CYC) |-> !col [*8])
    else $error("heartbeat started without its gap");
endmodule

// file: hdl/mmdp_pkg.sv
// ============================================================
// mmdp_pkg: constants, register map and types of the phy-side controller
// assumes ref_clk at 250 MHz and a 32-bit software port with byte addresses
package mmdp_pkg;

  // ============================================================
  // clock and timing
  localparam int REF_CLK_MHZ = 250;
  localparam int MII_PERIOD_100_NS = 40;    // 25 MHz link clock
  localparam int MII_PERIOD_10_NS = 400;    // 2.5 MHz link clock
  localparam int BIT_TIME_10_NS = 100;      // one bit at 10 Mb/s
  localparam int COL_DELAY_BITS = 7;        // bits seen in collision before reporting
  localparam int SQE_DELAY_NS = 1000;       // gap from end of transmit to heartbeat
  localparam int SQE_LEN_BITS = 10;         // heartbeat length in bit times
  localparam logic [5:0] HALF_100 = 6'((MII_PERIOD_100_NS / 2) * REF_CLK_MHZ / 1000);
  localparam logic [5:0] HALF_10 = 6'((MII_PERIOD_10_NS / 2) * REF_CLK_MHZ / 1000);
  localparam logic [9:0] COL_DELAY_CYC =
    10'(COL_DELAY_BITS * BIT_TIME_10_NS * REF_CLK_MHZ / 1000);
  localparam logic [9:0] SQE_LEN_CYC = 10'(SQE_LEN_BITS * BIT_TIME_10_NS * REF_CLK_MHZ / 1000);
  localparam logic [9:0] SQE_DELAY_CYC = 10'(SQE_DELAY_NS * REF_CLK_MHZ / 1000);

  // ============================================================
  // management frame
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h09;
  localparam logic [4:0] LAST_DATA_BIT = 5'h0f;
  localparam int MG_REGS = 32;

  // ============================================================
  // software register map (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_RX_DATA = 8'h08;
  localparam logic [7:0] A_TX_DATA = 8'h0c;
  localparam logic [7:0] A_MG_SEL = 8'h10;
  localparam logic [7:0] A_MG_DATA = 8'h14;
  localparam logic [4:0] PHY_ADDR_RST = 5'h01;

  // ============================================================
  // types
  typedef struct packed {
    logic [4:0] phy_addr;       // bits 8:4
    logic rx_carrier;           // bit 3: receive activity without data
    logic heartbeat_en;         // bit 2
    logic full_duplex;          // bit 1
    logic speed_100;            // bit 0
  } mmdp_ctrl_t;

  typedef struct packed {
    logic err;                  // bit 4
    logic [3:0] nibble;         // bits 3:0
  } mmdp_rx_t;

  typedef enum logic [2:0] {
    MG_PRE = 3'h0,
    MG_START = 3'h1,
    MG_OP = 3'h2,
    MG_ADDR = 3'h3,
    MG_TA = 3'h4,
    MG_DATA = 3'h5
  } mmdp_mg_state_t;

endpackage

// file: hdl/mmdp_sync2.sv
// ============================================================
// mmdp_sync2: two flip-flop synchroniser for a group of levels
// assumes inputs come from outside the ref_clk domain
`timescale 1ns/100ps
module mmdp_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// file: hdl/mmdp_edge.sv
// ============================================================
// mmdp_edge: synchronises a slow clock pin and reports its edges
// assumes the pin is at most a tenth of ref_clk, any rate below that
`timescale 1ns/100ps
module mmdp_edge (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // pin and events
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic meta;
  logic sync;
  logic prev;

  // two stages, then a history bit for edge finding
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign rise = sync & ~prev;
  assign fall = ~sync & prev;
endmodule

// file: sim/mmdp_mac_model.sv
// ============================================================
// mmdp_mac_model: station side of the mii, pins set through its own registers
// assumes the bench writes registers on ref_clk and resolves the mdio wire
`timescale 1ns/100ps
module mmdp_mac_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port, read data combinational
  input wire logic [7:0] m_addr,
  input wire logic [31:0] m_wdata,
  input wire logic m_wr,
  output logic [31:0] m_rdata,
  // mii pins
  output logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic [3:0] txd,
  output logic tx_en
);
  logic ext_sel;
  logic [2:0] pin_bits;
  logic [4:0] tx_bits;

  // register writes: 04 config, 08 pin access, 0c transmit pins; no timing of its own
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sel <= 1'b0;
      pin_bits <= 3'h0;
      tx_bits <= 5'h00;
    end else if (m_wr) begin
      if (m_addr == 8'h04) ext_sel <= m_wdata[12];
      if (m_addr == 8'h08) pin_bits <= m_wdata[6:4];
      if (m_addr == 8'h0c) tx_bits <= m_wdata[4:0];
    end
  end

  // register reads; internal phy disabled flag mirrors the select bit
  always_comb begin
    m_rdata = 32'h0;
    if (m_addr == 8'h04) m_rdata = {19'h0, ext_sel, 2'h0, ext_sel, 9'h0};
    if (m_addr == 8'h08) m_rdata = {25'h0, pin_bits[2:1],
      pin_bits[1] ? pin_bits[0] : mdio_in, 4'h0};
  end

  // mdc, mdio_oe and tx_en follow the register bits only once the mii is selected; mdio_out and txd always do
  assign mdc = ext_sel & pin_bits[2];
  assign mdio_oe = ext_sel & pin_bits[1];
  assign mdio_out = pin_bits[0];
  assign txd = tx_bits[3:0];
  assign tx_en = ext_sel & tx_bits[4];
endmodule

// file: sim/test_mii_mgmt_and_data_port.sv
// ============================================================
// test_mii_mgmt_and_data_port: bench for the phy-side controller
// assumes the design drives rx_clk itself; mdio has a pull-up
`timescale 1ns/100ps
module test_mii_mgmt_and_data_port;
  import mmdp_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rd_data;
  logic [7:0] m_addr = 8'h00;
  logic [31:0] m_wdata = 32'h0;
  logic m_wr = 1'b0;
  logic [31:0] m_rdata;
  logic mdc, d_out, d_oe, m_out, m_oe, mdio_w, rx_clk, rx_dv, rx_er, tx_clk, tx_en, crs, col;
  logic [3:0] rxd, txd;
  int n_errors = 0;
  int num_checks = 0;
  logic [31:0] v;
  logic [17:0] r;
  int i;
  realtime t0;

  // ============================================================
  // clock, reset, wire resolution
  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
  end
  assign mdio_w = d_oe ? d_out : (m_oe ? m_out : 1'b1); // released line pulled high

  mmdp_phy_ctrl u_mmdp_phy_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .mdc(mdc),
    .mdio_in(mdio_w), .mdio_out(d_out), .mdio_oe(d_oe), .rx_clk(rx_clk), .rxd(rxd),
    .rx_dv(rx_dv), .rx_er(rx_er), .tx_clk(tx_clk), .txd(txd), .tx_en(tx_en), .crs(crs),
    .col(col));
  mmdp_mac_model u_mmdp_mac_model (.ref_clk(ref_clk), .rst_n(rst_n), .m_addr(m_addr),
    .m_wdata(m_wdata), .m_wr(m_wr), .m_rdata(m_rdata), .mdc(mdc), .mdio_in(mdio_w),
    .mdio_out(m_out), .mdio_oe(m_oe), .txd(txd), .tx_en(tx_en));

  // ============================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic mac_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    m_addr <= a;
    m_wdata <= d;
    m_wr <= 1'b1;
    @(posedge ref_clk);
    m_wr <= 1'b0;
  endtask
  task automatic mac_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    m_addr <= a;
    #1 d = m_rdata;
  endtask
  // one management clock: low then high, data sampled while high
  task automatic mg_bit(input logic drv, input logic b, output logic got);
    logic [31:0] p;
    mac_wr(8'h08, {25'h0, 1'b0, drv, b, 4'h0});
    repeat (6) @(posedge ref_clk);
    mac_wr(8'h08, {25'h0, 1'b1, drv, b, 4'h0});
    repeat (6) @(posedge ref_clk);
    mac_rd(8'h08, p);
    got = p[4];
  endtask
  // whole frame: driven preamble, start, op, addresses, turnaround, data
  task automatic mg_frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] wd, output logic [17:0] q);
    logic [63:0] f;
    logic g;
    f = {32'hffff_ffff, 2'b01, op, pa, ra, 2'b10, wd};
    for (int k = 63; k >= 0; k--) begin
      mg_bit(!(op == OP_READ && k < 18), f[k], g);
      if (k < 18) q[k] = g;
    end
    mac_wr(8'h08, 32'h0);
  endtask

  // ============================================================
  // scenarios
  task automatic t_regs;
    sw_rd(A_CTRL, v);
    check("ctrl reset", {23'h0, PHY_ADDR_RST, 4'h0}, v);
    sw_rd(8'h20, v);
    check("unmapped read", 32'h0, v);
    mac_wr(8'h08, 32'h40);
    #1 check("mdc without select", 32'h0, {31'h0, mdc});
    mac_wr(8'h04, 32'h1200);
    mac_rd(8'h04, v);
    check("config select", 32'h1200, v);
  endtask
  task automatic t_mg;
    mg_frame(OP_WRITE, PHY_ADDR_RST, 5'h03, 16'hbeef, r);
    sw_wr(A_MG_SEL, 32'h3);
    sw_rd(A_MG_DATA, v);
    check("mgmt write", 32'hbeef, v);
    mg_frame(OP_READ, PHY_ADDR_RST, 5'h03, 16'h0, r);
    check("mgmt read", {14'h0, 1'b0, 16'hbeef, 1'b1}, {14'h0, r});
    mg_frame(OP_READ, 5'h1f, 5'h03, 16'h0, r);
    check("other address", 32'h3ffff, {14'h0, r});
    mg_frame(2'b11, PHY_ADDR_RST, 5'h03, 16'h1234, r);
    sw_rd(A_STATUS, v);
    check("frame error", 32'h1, {31'h0, v[8]});
    sw_rd(A_STATUS, v);
    check("frame error cleared", 32'h0, {31'h0, v[8]});
    sw_rd(A_MG_DATA, v);
    check("bad frame dropped", 32'hbeef, v);
  endtask
  task automatic t_rx;
    @(posedge rx_clk);
    t0 = $realtime;
    @(posedge rx_clk);
    check("rx clock period", 32'(MII_PERIOD_10_NS), 32'(int'($realtime - t0)));
    #1 check("tx clock", {31'h0, rx_clk}, {31'h0, tx_clk});
    sw_wr(A_RX_DATA, 32'h15);
    for (i = 0; i < 300 && rx_dv !== 1'b1; i++) @(posedge ref_clk);
    check("rx nibble", 32'h15, {27'h0, rx_er, rxd});
    repeat (2) @(posedge ref_clk);
    check("crs on rx", 32'h1, {31'h0, crs});
    for (i = 0; i < 300 && rx_dv !== 1'b0; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    check("crs after rx", 32'h0, {30'h0, crs, rx_dv});
  endtask
  task automatic t_col;
    mac_wr(8'h0c, 32'h1a);
    repeat (250) @(posedge ref_clk);
    sw_rd(A_TX_DATA, v);
    check("tx nibble", 32'ha, {28'h0, v[3:0]});
    check("crs on tx", 32'h1, {31'h0, crs});
    sw_wr(A_CTRL, 32'h18);
    repeat (100) @(posedge ref_clk);
    check("col delayed", 32'h0, {31'h0, col});
    repeat (150) @(posedge ref_clk);
    check("col after 7 bits", 32'h1, {31'h0, col});
    mac_wr(8'h0c, 32'h0);
    repeat (300) @(posedge ref_clk);
    mac_wr(8'h0c, 32'h1a);
    repeat (130) @(posedge ref_clk);
    check("col while rx", 32'h1, {31'h0, col});
    mac_wr(8'h0c, 32'h0);
    repeat (300) @(posedge ref_clk);
    sw_wr(A_CTRL, 32'h14);
    mac_wr(8'h0c, 32'h1a);
    repeat (250) @(posedge ref_clk);
    mac_wr(8'h0c, 32'h0);
    for (i = 0; i < 900 && col !== 1'b1; i++) @(posedge ref_clk);
    for (i = 0; i < 600 && col === 1'b1; i++) @(posedge ref_clk);
    check("heartbeat length", 32'(SQE_LEN_CYC), i);
  endtask
  task automatic t_fdx;
    sw_wr(A_CTRL, 32'h12);
    mac_wr(8'h0c, 32'h1a);
    repeat (300) @(posedge ref_clk);
    check("fdx tx crs col", 32'h0, {30'h0, crs, col});
    sw_wr(A_CTRL, 32'h1a);
    repeat (3) @(posedge ref_clk);
    check("fdx rx crs col", 32'h2, {30'h0, crs, col});
    sw_wr(A_CTRL, 32'h19);
    repeat (3) @(posedge ref_clk);
    check("col at 100", 32'h1, {31'h0, col});
    @(posedge rx_clk);
    t0 = $realtime;
    @(posedge rx_clk);
    check("rx clock 100", 32'(MII_PERIOD_100_NS), 32'(int'($realtime - t0)));
    mac_wr(8'h0c, 32'h0);
  endtask

  // ============================================================
  // verdict, watchdog and main sequence
  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    wrap_up;
  end
  initial begin
    @(posedge rst_n);
    t_regs;
    t_mg;
    t_rx;
    t_col;
    t_fdx;
    wrap_up;
  end
endmodule
